// ### shared/crtsb_pkg.sv
// crtsb_pkg: register indices, field layouts and port addresses for the sync/blank timing block
`default_nettype none
package crtsb_pkg;
  // indexed port pair, monochrome and colour emulation
  localparam logic [15:0] PORT_MONO_INDEX  = 16'h03b4;
  localparam logic [15:0] PORT_MONO_DATA   = 16'h03b5;
  localparam logic [15:0] PORT_COLOR_INDEX = 16'h03d4;
  localparam logic [15:0] PORT_COLOR_DATA  = 16'h03d5;
  localparam logic [7:0]  INDEX_RESET      = 8'h00;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED    = 8'h00;

  // storage slots and the index each answers to
  localparam int unsigned NUM_SLOTS = 14;
  localparam int unsigned SLOT_W    = 4;
  localparam logic [3:0] S_HBLANK_END  = 4'h0;
  localparam logic [3:0] S_HSYNC_START = 4'h1;
  localparam logic [3:0] S_HSYNC_END   = 4'h2;
  localparam logic [3:0] S_VTOTAL_LOW  = 4'h3;
  localparam logic [3:0] S_OVERFLOW    = 4'h4;
  localparam logic [3:0] S_MAX_SCAN    = 4'h5;
  localparam logic [3:0] S_VSYNC_START = 4'h6;
  localparam logic [3:0] S_VDISP_END   = 4'h7;
  localparam logic [3:0] S_VBLANK_ST   = 4'h8;
  localparam logic [3:0] S_LINE_CMP    = 4'h9;
  localparam logic [3:0] S_EXT_VTOTAL  = 4'ha;
  localparam logic [3:0] S_EXT_VDISP   = 4'hb;
  localparam logic [3:0] S_EXT_VSYNC   = 4'hc;
  localparam logic [3:0] S_EXT_VBLANK  = 4'hd;
  localparam logic [7:0] SLOT_INDEX [NUM_SLOTS] = '{
    8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h10,
    8'h12, 8'h15, 8'h18, 8'h30, 8'h31, 8'h32, 8'h33};

  // field positions
  localparam int unsigned HBE_LOW_W    = 5;
  localparam int unsigned HBE_RSVD_BIT = 7;
  localparam int unsigned HSE_HBE5_BIT = 7;
  localparam int unsigned HSE_DLY_LSB  = 5;
  localparam int unsigned HSE_END_W    = 5;
  localparam int unsigned OVF_VT8      = 0;
  localparam int unsigned OVF_VD8      = 1;
  localparam int unsigned OVF_VS8      = 2;
  localparam int unsigned OVF_VB8      = 3;
  localparam int unsigned OVF_LC8      = 4;
  localparam int unsigned OVF_VT9      = 5;
  localparam int unsigned OVF_VD9      = 6;
  localparam int unsigned OVF_VS9      = 7;
  localparam int unsigned MSL_VB9      = 5;
  localparam int unsigned MSL_LC9      = 6;
  localparam int unsigned EXT_W        = 4;
  localparam int unsigned VCNT_W       = 12;
  localparam int unsigned LCMP_W       = 10;
  localparam int unsigned MAX_DELAY    = 3;
endpackage
`default_nettype wire

// ### design/crtsb_timing_regs.sv
// crtsb_timing_regs: indexed timing registers, assembled counts and delayed horizontal sync
// Behaviour
// - each register reached by writing its index, then accessing the data port
// - blank end is six bits: register field 4-0 plus sync-end bit 7
// - sync start gives the character clock where horizontal sync begins
// - five-bit sync end is low bits of start plus pulse width
// - delay field shifts both sync edges by zero to three character clocks
// - io control bit 0 picks ten-bit standard or twelve-bit extended counts
// - standard vertical total: low byte, bit 9 overflow 5, bit 8 overflow 0
// - extended vertical total: top nibble from extended total register
// - standard vsync start: low byte, bit 9 overflow 7, bit 8 overflow 2
// - extended vsync start: top nibble from extended sync start register
// - vsync start is the scan line number, line zero first active
// - standard display end: low byte, bit 9 overflow 6, bit 8 overflow 1
// - extended display end: top nibble from extended display end register
// - line compare uses overflow bit 4 as bit 8; restarts address there
// - standard blank start: overflow bit 3 is bit 8, max-scan bit 5 bit 9
`timescale 1ns/10ps
`default_nettype none
module crtsb_timing_regs (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // host i/o port pair
  input  wire logic [15:0] io_addr_in,
  input  wire logic        io_wr_in,
  input  wire logic        io_rd_in,
  input  wire logic [7:0]  io_wdata_in,
  output logic      [7:0]  io_rdata_out,
  // configuration from neighbouring logic
  input  wire logic        color_sel_in,
  input  wire logic        ext_mode_in,
  // raster counters
  input  wire logic        char_tick_in,
  input  wire logic [7:0]  char_count_in,
  input  wire logic        line_tick_in,
  input  wire logic [11:0] line_count_in,
  // timing results
  output logic             hsync_out,
  output logic             addr_restart_out,
  output logic      [5:0]  hblank_end_out,
  output logic      [11:0] vtotal_out,
  output logic      [11:0] vsync_start_out,
  output logic      [11:0] vdisp_end_out,
  output logic      [11:0] vblank_start_out,
  output logic      [9:0]  line_compare_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  index;
  logic [7:0]  regs [crtsb_pkg::NUM_SLOTS];
  logic [7:0]  next_index;
  logic [7:0]  next_regs [crtsb_pkg::NUM_SLOTS];
  logic [7:0]  next_rdata;
  logic        sync_raw;
  logic        next_sync_raw;
  logic [2:0]  sync_dly;
  logic [2:0]  next_sync_dly;
  logic        next_hsync;
  logic        next_restart;
  logic [5:0]  next_hbe;
  logic [11:0] next_vt;
  logic [11:0] next_vs;
  logic [11:0] next_vd;
  logic [11:0] next_vb;
  logic [9:0]  next_lc;
  logic [crtsb_pkg::NUM_SLOTS-1:0] slot_hit;
  logic        sel_index;
  logic        sel_data;
  logic [7:0]  hse;
  logic [7:0]  ovf;
  logic [7:0]  msl;
  logic [1:0]  dly_sel;

  // only the port pair of the current emulation answers
  assign sel_index = (io_addr_in == (color_sel_in ? crtsb_pkg::PORT_COLOR_INDEX
                                                  : crtsb_pkg::PORT_MONO_INDEX));
  assign sel_data  = (io_addr_in == (color_sel_in ? crtsb_pkg::PORT_COLOR_DATA
                                                  : crtsb_pkg::PORT_MONO_DATA));
  assign hse = regs[crtsb_pkg::S_HSYNC_END];
  assign ovf = regs[crtsb_pkg::S_OVERFLOW];
  assign msl = regs[crtsb_pkg::S_MAX_SCAN];
  assign dly_sel = hse[crtsb_pkg::HSE_DLY_LSB +: 2];

  // index decode, one comparator per stored register
  genvar g;
  generate
    for (g = 0; g < crtsb_pkg::NUM_SLOTS; g++) begin : g_decode
      assign slot_hit[g] = (index == crtsb_pkg::SLOT_INDEX[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_index = index;
    next_rdata = io_rdata_out;
    for (int i = 0; i < crtsb_pkg::NUM_SLOTS; i++) begin
      next_regs[i] = regs[i];
    end
    // host access through the index/data pair
    if (io_wr_in && sel_index) begin
      next_index = io_wdata_in;
    end
    if (io_wr_in && sel_data) begin
      for (int i = 0; i < crtsb_pkg::NUM_SLOTS; i++) begin
        if (slot_hit[i]) begin
          next_regs[i] = io_wdata_in;
        end
      end
    end
    if (io_rd_in && sel_index) begin
      next_rdata = index;
    end else if (io_rd_in && sel_data) begin
      next_rdata = crtsb_pkg::READ_UNMAPPED;
      for (int i = 0; i < crtsb_pkg::NUM_SLOTS; i++) begin
        if (slot_hit[i]) begin
          next_rdata = regs[i];
        end
      end
      // legacy reserved bit always reads back set
      if (slot_hit[crtsb_pkg::S_HBLANK_END]) begin
        next_rdata[crtsb_pkg::HBE_RSVD_BIT] = 1'b1;
      end
    end

    // assembled counts; the unused overflow bits are simply not looked at
    next_hbe = {hse[crtsb_pkg::HSE_HBE5_BIT],
                regs[crtsb_pkg::S_HBLANK_END][crtsb_pkg::HBE_LOW_W-1:0]};
    if (ext_mode_in) begin
      next_vt = {regs[crtsb_pkg::S_EXT_VTOTAL][crtsb_pkg::EXT_W-1:0],
                 regs[crtsb_pkg::S_VTOTAL_LOW]};
      next_vs = {regs[crtsb_pkg::S_EXT_VSYNC][crtsb_pkg::EXT_W-1:0],
                 regs[crtsb_pkg::S_VSYNC_START]};
      next_vd = {regs[crtsb_pkg::S_EXT_VDISP][crtsb_pkg::EXT_W-1:0],
                 regs[crtsb_pkg::S_VDISP_END]};
      next_vb = {regs[crtsb_pkg::S_EXT_VBLANK][crtsb_pkg::EXT_W-1:0],
                 regs[crtsb_pkg::S_VBLANK_ST]};
    end else begin
      next_vt = {2'h0, ovf[crtsb_pkg::OVF_VT9], ovf[crtsb_pkg::OVF_VT8],
                 regs[crtsb_pkg::S_VTOTAL_LOW]};
      next_vs = {2'h0, ovf[crtsb_pkg::OVF_VS9], ovf[crtsb_pkg::OVF_VS8],
                 regs[crtsb_pkg::S_VSYNC_START]};
      next_vd = {2'h0, ovf[crtsb_pkg::OVF_VD9], ovf[crtsb_pkg::OVF_VD8],
                 regs[crtsb_pkg::S_VDISP_END]};
      next_vb = {2'h0, msl[crtsb_pkg::MSL_VB9], ovf[crtsb_pkg::OVF_VB8],
                 regs[crtsb_pkg::S_VBLANK_ST]};
    end
    next_lc = {msl[crtsb_pkg::MSL_LC9], ovf[crtsb_pkg::OVF_LC8],
               regs[crtsb_pkg::S_LINE_CMP]};
    // restart pulse on the line tick of the matching scan line
    next_restart = line_tick_in && (line_count_in == {2'h0, line_compare_out});

    // horizontal sync: start match wins over end match in the same character
    next_sync_raw = sync_raw;
    next_sync_dly = sync_dly;
    if (char_tick_in) begin
      if (char_count_in == regs[crtsb_pkg::S_HSYNC_START]) begin
        next_sync_raw = 1'b1;
      end else if (char_count_in[crtsb_pkg::HSE_END_W-1:0]
                   == hse[crtsb_pkg::HSE_END_W-1:0]) begin
        next_sync_raw = 1'b0;
      end
      // delay line moves in character steps, so both edges shift alike
      next_sync_dly = {sync_dly[1:0], sync_raw};
    end
    case (dly_sel)
      2'h0:    next_hsync = sync_raw;
      2'h1:    next_hsync = sync_dly[0];
      2'h2:    next_hsync = sync_dly[1];
      2'h3:    next_hsync = sync_dly[2];
      default: next_hsync = sync_raw;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      index            <= crtsb_pkg::INDEX_RESET;
      for (int i = 0; i < crtsb_pkg::NUM_SLOTS; i++) begin
        regs[i] <= crtsb_pkg::REG_RESET;
      end
      io_rdata_out     <= crtsb_pkg::REG_RESET;
      sync_raw         <= 1'b0;
      sync_dly         <= 3'h0;
      hsync_out        <= 1'b0;
      addr_restart_out <= 1'b0;
      hblank_end_out   <= 6'h00;
      vtotal_out       <= 12'h000;
      vsync_start_out  <= 12'h000;
      vdisp_end_out    <= 12'h000;
      vblank_start_out <= 12'h000;
      line_compare_out <= 10'h000;
    end else begin
      index            <= next_index;
      for (int i = 0; i < crtsb_pkg::NUM_SLOTS; i++) begin
        regs[i] <= next_regs[i];
      end
      io_rdata_out     <= next_rdata;
      sync_raw         <= next_sync_raw;
      sync_dly         <= next_sync_dly;
      hsync_out        <= next_hsync;
      addr_restart_out <= next_restart;
      hblank_end_out   <= next_hbe;
      vtotal_out       <= next_vt;
      vsync_start_out  <= next_vs;
      vdisp_end_out    <= next_vd;
      vblank_start_out <= next_vb;
      line_compare_out <= next_lc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks against the port, count assembly, line compare and sync behaviour
  a_index_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    io_wr_in && sel_index ##1 !(io_wr_in && sel_index) ##1 io_rd_in && sel_index && !io_wr_in
      |=> io_rdata_out == $past(io_wdata_in, 3))
    else $error("index port read does not return written index");

  a_vtotal_low_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    io_wr_in && sel_data && index == crtsb_pkg::SLOT_INDEX[crtsb_pkg::S_VTOTAL_LOW]
      ##1 !(io_wr_in && sel_data) |=> vtotal_out[7:0] == $past(io_wdata_in, 2))
    else $error("vertical total low byte not taken from data port");

  a_hbe_assembly: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    io_wr_in && sel_data && index == crtsb_pkg::SLOT_INDEX[crtsb_pkg::S_HSYNC_END]
      ##1 !(io_wr_in && sel_data) |=> hblank_end_out[5] == $past(io_wdata_in[7], 2))
    else $error("blank end bit 5 not taken from sync end bit 7");

  a_std_mode_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ext_mode_in |=> vtotal_out[11:10] == 2'h0 && vsync_start_out[11:10] == 2'h0
      && vdisp_end_out[11:10] == 2'h0 && vtotal_out[9] == $past(ovf[crtsb_pkg::OVF_VT9]))
    else $error("standard mode count wider than ten bits");

  a_ext_vtotal_top: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_mode_in |=> vtotal_out[11:8] == $past(regs[crtsb_pkg::S_EXT_VTOTAL][3:0]))
    else $error("extended vertical total top nibble wrong");

  a_vsync_std_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ext_mode_in |=> vsync_start_out[9:8] == {$past(ovf[7]), $past(ovf[2])})
    else $error("vertical sync start high bits wrong in standard mode");

  a_vdisp_ext_top: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_mode_in |=> vdisp_end_out[11:8] == $past(regs[crtsb_pkg::S_EXT_VDISP][3:0]))
    else $error("extended display end top nibble wrong");

  a_line_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    addr_restart_out |-> $past(line_tick_in) && $past(line_count_in[9:0]) == $past(line_compare_out))
    else $error("address restart off the compare line");

  a_sync_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    char_tick_in && char_count_in == regs[crtsb_pkg::S_HSYNC_START] && dly_sel == 2'h0
      ##1 dly_sel == 2'h0 |=> hsync_out)
    else $error("sync did not rise on start match");

  a_sync_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dly_sel == 2'h3 |=> hsync_out == $past(sync_dly[2]))
    else $error("sync delay tap wrong");

endmodule
`default_nettype wire

// ### dv/crtsb_monitor.sv
// crtsb_monitor: display-side receiver that measures each horizontal sync pulse
`timescale 1ns/10ps
`default_nettype none
module crtsb_monitor (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // raster position and sync seen at the display
  input  wire logic       hsync_in,
  input  wire logic       char_tick_in,
  input  wire logic [7:0] char_count_in,
  // measurements
  output logic      [7:0] rise_pos_out,
  output logic      [7:0] width_out,
  output logic      [7:0] pulses_out
);
  logic       h_q;
  logic [7:0] run;

  ////////////////////////////////////////////////////////////////////////////
  // position of leading edge, width in character clocks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      h_q          <= 1'b0;
      run          <= 8'h00;
      rise_pos_out <= 8'h00;
      width_out    <= 8'h00;
      pulses_out   <= 8'h00;
    end else begin
      h_q <= hsync_in;
      if (hsync_in && !h_q) begin
        rise_pos_out <= char_count_in;
        run          <= 8'h00;
      end else if (hsync_in && char_tick_in) begin
        run <= run + 8'h01;
      end
      if (!hsync_in && h_q) begin
        width_out  <= run;
        pulses_out <= pulses_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_crtsb_timing_regs.sv
// tb_crtsb_timing_regs: register access, count assembly and sync timing tests
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_crtsb_timing_regs;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, csel = 1'b1, ext = 1'b0;
  logic        ctick = 1'b0, ltick = 1'b0, hsync, restart;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, ccount = 8'h00, rdata, rise, width, pulses, p0;
  logic [11:0] lcount = 12'h000, vtotal, vsync, vdisp, vblank;
  logic [9:0]  lcmp;
  logic [5:0]  hbe;
  logic [1:0]  cdiv = 2'b00;
  logic [7:0]  sh [256];
  int          n_fail = 0, checks = 0;

  crtsb_timing_regs u_dut (.clk_in(clk), .rst_n_in(rst_n), .io_addr_in(addr),
    .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata), .io_rdata_out(rdata),
    .color_sel_in(csel), .ext_mode_in(ext), .char_tick_in(ctick),
    .char_count_in(ccount), .line_tick_in(ltick), .line_count_in(lcount),
    .hsync_out(hsync), .addr_restart_out(restart), .hblank_end_out(hbe),
    .vtotal_out(vtotal), .vsync_start_out(vsync), .vdisp_end_out(vdisp),
    .vblank_start_out(vblank), .line_compare_out(lcmp));
  crtsb_monitor u_mon (.clk_in(clk), .rst_n_in(rst_n), .hsync_in(hsync),
    .char_tick_in(ctick), .char_count_in(ccount), .rise_pos_out(rise),
    .width_out(width), .pulses_out(pulses));

  initial begin
    forever #2.5 clk = ~clk;
  end
  // 64-character line, one character every four clocks
  always @(posedge clk) begin
    cdiv  <= cdiv + 2'b01;
    ctick <= (cdiv == 2'b11);
    if (cdiv == 2'b11) ccount <= (ccount + 8'h01) & 8'h3f;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
    logic [15:0] pb;
    pb = csel ? crtsb_pkg::PORT_COLOR_INDEX : crtsb_pkg::PORT_MONO_INDEX;
    acc(pb, 1'b1, i);
    acc(pb + 16'h0001, 1'b1, d);
    sh[i] = d;
  endtask
  task automatic rd_reg(input logic [7:0] i, input logic [7:0] e);
    logic [15:0] pb;
    pb = csel ? crtsb_pkg::PORT_COLOR_INDEX : crtsb_pkg::PORT_MONO_INDEX;
    acc(pb, 1'b1, i);
    acc(pb + 16'h0001, 1'b0, 8'h00);
    `CHK(rdata, e)
  endtask
  // outputs are registered, so let the write settle three cycles
  task automatic chk_v;
    logic [7:0] o;
    o = sh[8'h07];
    repeat (3) @(posedge clk);
    #1;
    if (ext) begin
      `CHK(vtotal, {sh[8'h30][3:0], sh[8'h06]})
      `CHK(vsync, {sh[8'h32][3:0], sh[8'h10]})
      `CHK(vdisp, {sh[8'h31][3:0], sh[8'h12]})
      `CHK(vblank, {sh[8'h33][3:0], sh[8'h15]})
    end else begin
      `CHK(vtotal, {2'b00, o[5], o[0], sh[8'h06]})
      `CHK(vsync, {2'b00, o[7], o[2], sh[8'h10]})
      `CHK(vdisp, {2'b00, o[6], o[1], sh[8'h12]})
      `CHK(vblank, {2'b00, sh[8'h09][5], o[3], sh[8'h15]})
    end
    `CHK(lcmp, {sh[8'h09][6], o[4], sh[8'h18]})
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 4; i < 8; i++) rd_reg(i[7:0], crtsb_pkg::REG_RESET);
    rd_reg(8'h03, 8'h80);
    rd_reg(8'h08, crtsb_pkg::READ_UNMAPPED);
    acc(crtsb_pkg::PORT_COLOR_INDEX, 1'b1, 8'h33);
    acc(crtsb_pkg::PORT_COLOR_INDEX, 1'b0, 8'h00);
    `CHK(rdata, 8'h33)
    for (int i = 4; i < 8; i++) wr_reg(i[7:0], 8'ha0 + i[7:0]);
    for (int i = 4; i < 8; i++) rd_reg(i[7:0], 8'ha0 + i[7:0]);
    // wr_reg picks its port from csel, so let the change land first
    @(posedge clk);
    csel <= 1'b0;
    #1;
    wr_reg(8'h04, 8'h3c);
    @(posedge clk);
    csel <= 1'b1;
    #1;
    acc(crtsb_pkg::PORT_MONO_DATA, 1'b1, 8'hff);
    rd_reg(8'h04, 8'h3c);
    $display("test registers done");
    // software values: 0x35c lines per frame, programmed minus two; last active line 0x07c
    wr_reg(8'h06, 8'h5a);
    wr_reg(8'h10, 8'h6b);
    wr_reg(8'h12, 8'h7c);
    wr_reg(8'h15, 8'h8d);
    wr_reg(8'h09, 8'h60);
    wr_reg(8'h18, 8'h20);
    wr_reg(8'h30, 8'h0c);
    wr_reg(8'h31, 8'h03);
    wr_reg(8'h32, 8'h0a);
    wr_reg(8'h33, 8'h05);
    wr_reg(8'h07, 8'ha5);
    chk_v();
    wr_reg(8'h07, 8'h5a);
    chk_v();
    @(posedge clk);
    ext <= 1'b1;
    chk_v();
    @(posedge clk);
    ext <= 1'b0;
    // blank end is register 0x03 bits 4-0 plus sync-end bit 7 as bit 5
    wr_reg(8'h03, 8'h15);
    wr_reg(8'h05, 8'h80);
    chk_v();
    `CHK(hbe, 6'h35)
    $display("test assembly done");
    @(posedge clk);
    ltick  <= 1'b1;
    lcount <= {2'b00, lcmp};
    @(posedge clk);
    ltick <= 1'b0;
    #1;
    `CHK(restart, 1'b1)
    @(posedge clk);
    #1;
    `CHK(restart, 1'b0)
    $display("test line compare done");
    // sync from character 0x10, five characters wide
    wr_reg(8'h04, 8'h10);
    for (int d = 0; d < 4; d++) begin
      wr_reg(8'h05, {1'b0, d[1:0], 5'h15});
      p0 = pulses;
      for (int k = 0; k < 2000 && pulses != p0 + 8'h02; k++) @(posedge clk);
      #1;
      `CHK(pulses, p0 + 8'h02)
      `CHK(rise, 8'h10 + d[7:0])
      `CHK(width, 8'h05)
    end
    `CHK(hbe, 6'h15)
    $display("test sync timing done");
    end_of_test();
  end
endmodule
`default_nettype wire
